// ---- design/dcs_regs.svh ----
// Register offsets, field positions, reset values for the DMA channel block.
// Assumes a 32-bit classic Wishbone bus with an 8-bit byte address; 16-bit data in low bits.
`ifndef DCS_REGS_SVH
`define DCS_REGS_SVH

// ************************************************************
// Channel register offsets (channel base = channel * stride)
// ************************************************************
`define DCS_CHAN_STRIDE 8'h20
`define DCS_OFS_CTRL 3'h0
`define DCS_OFS_PRIM_HI 3'h1
`define DCS_OFS_PRIM_LO 3'h2
`define DCS_OFS_SEC_HI 3'h3
`define DCS_OFS_SEC_LO 3'h4
`define DCS_OFS_PAD 3'h5
`define DCS_OFS_CNT 3'h6

// ************************************************************
// Shared status offsets (byte addresses)
// ************************************************************
`define DCS_ADR_LAST_HI 8'h80
`define DCS_ADR_LAST_LO 8'h84
`define DCS_ADR_PWC 8'h88
`define DCS_ADR_RQC 8'h8C
`define DCS_ADR_LCA 8'h90
`define DCS_ADR_PPS 8'h94

// ************************************************************
// Control fields and reset values
// ************************************************************
`define DCS_CTRL_ON 0
`define DCS_CTRL_PP 1
`define DCS_CTRL_FORCE 2
`define DCS_LCA_RESET 4'hF
`define DCS_FIFO_DEPTH 16

`endif

// ---- design/dcs_pkg.sv ----
// Types shared by the DMA channel block.
// Assumes nothing beyond a SystemVerilog compiler.
package dcs_pkg;
   // ************************************************************
   // Transfer engine states
   // ************************************************************
   typedef enum logic [1:0] {
      DCS_IDLE = 2'b01,
      DCS_WRITE = 2'b10
   } dcs_state_t;
endpackage

// ---- design/dcs_dma_channels.sv ----
// Four-channel DMA register file with transfer engine and data FIFO.
// Assumes requests and stream data come from logic on the same clock.
`timescale 1ns/1ps
`include "dcs_regs.svh"

// ************************************************************
// Data FIFO
// ************************************************************
module dcs_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [WIDTH-1:0] inData,
   input wire logic inValid,
   output logic inReady,
   output logic [WIDTH-1:0] outData,
   output logic outValid,
   input wire logic outReady
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr_reg;
   logic [AW-1:0] rdPtr_reg;
   logic [AW:0] count_reg;
   wire push = inValid && inReady;
   wire pop = outValid && outReady;

   // Full and empty from the occupancy count; DEPTH needs AW+1 bits
   assign inReady = (count_reg != (AW+1)'(DEPTH));
   assign outValid = (count_reg != '0);
   assign outData = mem[rdPtr_reg];

   // Storage has no reset; only pointers and count need defined values
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wrPtr_reg] <= inData;
      end
   end

   // Pointers and occupancy
   always_ff @(posedge clk) begin
      if (!resetn) begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (push) begin
            wrPtr_reg <= wrPtr_reg + AW'(1);
         end
         if (pop) begin
            rdPtr_reg <= rdPtr_reg + AW'(1);
         end
         if (push && !pop) begin
            count_reg <= count_reg + (AW+1)'(1);
         end else if (pop && !push) begin
            count_reg <= count_reg - (AW+1)'(1);
         end
      end
   end
endmodule

// Function
// - 24-bit primary start address, split high/low
// - 24-bit secondary start address, same split
// - 16-bit read/write peripheral address per channel
// - 14-bit count; block moves count plus one
// - Read-only 24-bit last RAM address accessed
// - Per-channel force/peripheral request collision flags
// - Ping-pong flag: one means secondary selected
// - Force self-clears on completion or disable
// - Ping-pong alternates buffers after each block
// - Four unidirectional channels, block-done interrupt
module dcs_dma_channels
   import dcs_pkg::*;
#(
   parameter int NCH = 4,
   parameter int FIFO_DEPTH = `DCS_FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [3:0] perReq,
   input wire logic [15:0] perData,
   input wire logic perValid,
   output logic perReady,
   output logic [23:0] ramAddr,
   output logic [15:0] ramData,
   output logic [15:0] periphAddr,
   output logic ramValid,
   input wire logic ramReady,
   output logic [3:0] blockDone
);
   // ************************************************************
   // Channel state
   // ************************************************************
   logic [23:0] primReg [NCH];
   logic [23:0] secReg [NCH];
   logic [15:0] padReg [NCH];
   logic [13:0] cntReg [NCH];
   logic [13:0] idxReg [NCH];
   logic [3:0] onReg;
   logic [3:0] ppModeReg;
   logic [3:0] forceReg;
   logic [3:0] pendReg;
   logic [3:0] pwcReg;
   logic [3:0] rqcReg;
   logic [3:0] ppsReg;
   logic [23:0] lastAddrReg;
   logic [3:0] lastChReg;
   logic [1:0] curChReg;
   logic ackReg;
   logic [31:0] datReg;
   logic [23:0] ramAddrReg;
   logic [15:0] ramDataReg;
   logic [15:0] padOutReg;
   logic [3:0] blockDoneReg;
   dcs_state_t stateReg;

   // Byte-lane merge of a 16-bit register under Wishbone select
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [15:0] nw,
                                           input logic [1:0] sel);
      merge16 = {sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
   endfunction

   // Fixed priority: lowest channel number wins
   function automatic logic [1:0] pickLow(input logic [3:0] req);
      pickLow = req[0] ? 2'h0 : req[1] ? 2'h1 : req[2] ? 2'h2 : 2'h3;
   endfunction

   // ************************************************************
   // Wishbone decode
   // ************************************************************
   wire busReq = wb_cyc_i && wb_stb_i && !ackReg;
   wire busWr = busReq && wb_we_i;
   wire chanSpace = (wb_adr_i < `DCS_ADR_LAST_HI);
   wire [1:0] adrCh = wb_adr_i[6:5];
   wire [2:0] adrOfs = wb_adr_i[4:2];
   wire [15:0] wrData = wb_dat_i[15:0];
   wire [1:0] wrSel = wb_sel_i[1:0];
   logic [31:0] rdMux;

   // Read selection; unmapped addresses answer zero
   always_comb begin
      rdMux = 32'h0000_0000;
      if (chanSpace && adrOfs == `DCS_OFS_CTRL) begin
         rdMux[2:0] = {forceReg[adrCh], ppModeReg[adrCh], onReg[adrCh]};
      end else if (chanSpace && adrOfs == `DCS_OFS_PRIM_HI) begin
         rdMux[7:0] = primReg[adrCh][23:16];
      end else if (chanSpace && adrOfs == `DCS_OFS_PRIM_LO) begin
         rdMux[15:0] = primReg[adrCh][15:0];
      end else if (chanSpace && adrOfs == `DCS_OFS_SEC_HI) begin
         rdMux[7:0] = secReg[adrCh][23:16];
      end else if (chanSpace && adrOfs == `DCS_OFS_SEC_LO) begin
         rdMux[15:0] = secReg[adrCh][15:0];
      end else if (chanSpace && adrOfs == `DCS_OFS_PAD) begin
         rdMux[15:0] = padReg[adrCh];
      end else if (chanSpace && adrOfs == `DCS_OFS_CNT) begin
         rdMux[13:0] = cntReg[adrCh];
      end else if (wb_adr_i == `DCS_ADR_LAST_HI) begin
         rdMux[7:0] = lastAddrReg[23:16];
      end else if (wb_adr_i == `DCS_ADR_LAST_LO) begin
         rdMux[15:0] = lastAddrReg[15:0];
      end else if (wb_adr_i == `DCS_ADR_PWC) begin
         rdMux[3:0] = pwcReg;
      end else if (wb_adr_i == `DCS_ADR_RQC) begin
         rdMux[3:0] = rqcReg;
      end else if (wb_adr_i == `DCS_ADR_LCA) begin
         rdMux[3:0] = lastChReg;
      end else if (wb_adr_i == `DCS_ADR_PPS) begin
         rdMux[3:0] = ppsReg;
      end
   end

   // One-cycle answer; read data captured with the ack
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ackReg <= 1'b0;
         datReg <= 32'h0000_0000;
      end else begin
         ackReg <= busReq;
         if (busReq && !wb_we_i) begin
            datReg <= rdMux;
         end
      end
   end

   assign wb_ack_o = ackReg;
   assign wb_dat_o = datReg;

   // ************************************************************
   // Transfer engine
   // ************************************************************
   logic [15:0] fifoData;
   logic fifoValid;
   wire [3:0] ready = pendReg & onReg;
   wire [1:0] pickCh = pickLow(ready);
   wire startXfer = (stateReg == DCS_IDLE) && (ready != 4'h0) && fifoValid;
   wire xferDone = (stateReg == DCS_WRITE) && ramReady;
   wire blockEnd = xferDone && (idxReg[curChReg] == cntReg[curChReg]);
   wire [23:0] pickBase = ppsReg[pickCh] ? secReg[pickCh] : primReg[pickCh];
   wire [23:0] pickAddr = pickBase + {10'h000, idxReg[pickCh]};

   // Word is popped when the engine commits to a transfer
   dcs_fifo #(
      .WIDTH(16),
      .DEPTH(FIFO_DEPTH)
   ) dataFifo (
      .clk(clk),
      .resetn(resetn),
      .inData(perData),
      .inValid(perValid),
      .inReady(perReady),
      .outData(fifoData),
      .outValid(fifoValid),
      .outReady(startXfer)
   );

   // Engine sequencing; RAM side may stall by holding ramReady low
   always_ff @(posedge clk) begin
      if (!resetn) begin
         stateReg <= DCS_IDLE;
         curChReg <= 2'h0;
         ramAddrReg <= 24'h00_0000;
         ramDataReg <= 16'h0000;
         padOutReg <= 16'h0000;
         lastAddrReg <= 24'h00_0000;
         lastChReg <= `DCS_LCA_RESET;
         blockDoneReg <= 4'h0;
      end else begin
         blockDoneReg <= 4'h0;
         case (stateReg)
            DCS_IDLE: begin
               if (startXfer) begin
                  stateReg <= DCS_WRITE;
                  curChReg <= pickCh;
                  ramAddrReg <= pickAddr;
                  ramDataReg <= fifoData;
                  padOutReg <= padReg[pickCh];
               end
            end
            DCS_WRITE: begin
               if (ramReady) begin
                  stateReg <= DCS_IDLE;
                  lastAddrReg <= ramAddrReg;
                  lastChReg <= {2'b00, curChReg};
                  if (blockEnd) begin
                     blockDoneReg[curChReg] <= 1'b1;
                  end
               end
            end
            default: begin
               stateReg <= DCS_IDLE;
            end
         endcase
      end
   end

   assign ramAddr = ramAddrReg;
   assign ramData = ramDataReg;
   assign periphAddr = padOutReg;
   assign ramValid = (stateReg == DCS_WRITE);
   assign blockDone = blockDoneReg;

   // ************************************************************
   // Per-channel registers and flags
   // ************************************************************
   always_ff @(posedge clk) begin
      if (!resetn) begin
         for (int c = 0; c < NCH; c++) begin
            primReg[c] <= 24'h00_0000;
            secReg[c] <= 24'h00_0000;
            padReg[c] <= 16'h0000;
            cntReg[c] <= 14'h0000;
            idxReg[c] <= 14'h0000;
         end
         onReg <= 4'h0;
         ppModeReg <= 4'h0;
         forceReg <= 4'h0;
         pendReg <= 4'h0;
         pwcReg <= 4'h0;
         rqcReg <= 4'h0;
         ppsReg <= 4'h0;
      end else begin
         for (int c = 0; c < NCH; c++) begin
            // Service first, then software, then new requests win last
            if (xferDone && curChReg == 2'(c)) begin
               pendReg[c] <= 1'b0;
               forceReg[c] <= 1'b0;
               if (blockEnd) begin
                  idxReg[c] <= 14'h0000;
                  if (ppModeReg[c]) begin
                     ppsReg[c] <= !ppsReg[c];
                  end else begin
                     onReg[c] <= 1'b0;
                  end
               end else begin
                  idxReg[c] <= idxReg[c] + 14'h0001;
               end
            end
            if (busWr && chanSpace && adrCh == 2'(c)) begin
               // Writes to PAD or count while enabled are the user's risk
               if (adrOfs == `DCS_OFS_CTRL && wrSel[0]) begin
                  onReg[c] <= wrData[`DCS_CTRL_ON];
                  ppModeReg[c] <= wrData[`DCS_CTRL_PP];
                  if (!wrData[`DCS_CTRL_ON]) begin
                     forceReg[c] <= 1'b0;
                     pendReg[c] <= 1'b0;
                     idxReg[c] <= 14'h0000;
                     ppsReg[c] <= 1'b0;
                     pwcReg[c] <= 1'b0;
                     rqcReg[c] <= 1'b0;
                  end else if (wrData[`DCS_CTRL_FORCE]) begin
                     forceReg[c] <= 1'b1;
                     pendReg[c] <= 1'b1;
                  end
               end
               if (adrOfs == `DCS_OFS_PRIM_HI && wrSel[0]) begin
                  primReg[c][23:16] <= wrData[7:0];
               end
               if (adrOfs == `DCS_OFS_PRIM_LO) begin
                  primReg[c][15:0] <= merge16(primReg[c][15:0], wrData,
                                              wrSel);
               end
               if (adrOfs == `DCS_OFS_SEC_HI && wrSel[0]) begin
                  secReg[c][23:16] <= wrData[7:0];
               end
               if (adrOfs == `DCS_OFS_SEC_LO) begin
                  secReg[c][15:0] <= merge16(secReg[c][15:0], wrData,
                                             wrSel);
               end
               if (adrOfs == `DCS_OFS_PAD) begin
                  padReg[c] <= merge16(padReg[c], wrData, wrSel);
               end
               if (adrOfs == `DCS_OFS_CNT) begin
                  cntReg[c] <= 14'(merge16({2'b00, cntReg[c]}, wrData,
                                           wrSel));
               end
            end
            // Peripheral requests; set beats every clear above
            if (perReq[c] && onReg[c]) begin
               pendReg[c] <= 1'b1;
               if (forceReg[c]) begin
                  rqcReg[c] <= 1'b1;
               end else if (pendReg[c] &&
                            !(xferDone && curChReg == 2'(c))) begin
                  pwcReg[c] <= 1'b1;
               end
            end
         end
      end
   end
endmodule

// ---- sim/dcs_checker.sv ----
// Port checks for the DMA channel block, bound to its top module.
// Assumes one clock and the synchronous active-low reset.
`timescale 1ns/1ps
// ************************************************************
// Checker
// ************************************************************
module dcs_checker #(
   parameter int NCH = 4,
   parameter int FIFO_DEPTH = 16
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic perReady,
   input wire logic [23:0] ramAddr,
   input wire logic [15:0] ramData,
   input wire logic [15:0] periphAddr,
   input wire logic ramValid,
   input wire logic ramReady,
   input wire logic [3:0] blockDone
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   // Bus answer timing and read width
   a_ack_follows: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   a_read_upper: assert property (
      wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
      else $error("upper read bits set");
   // A RAM offer stays put until taken, then drops
   a_ram_hold: assert property (ramValid && !ramReady |=> ramValid &&
      $stable(ramAddr) && $stable(ramData) && $stable(periphAddr))
      else $error("ram offer changed");
   a_ram_release: assert property (ramValid && ramReady |=> !ramValid)
      else $error("ram offer not dropped");
   // Block end only right after an accepted write, one channel, one cycle
   a_done_cause: assert property (
      blockDone != 4'h0 |-> $past(ramValid && ramReady))
      else $error("block end without write");
   a_done_pulse: assert property (blockDone != 4'h0 |->
      $onehot(blockDone) ##1 blockDone == 4'h0)
      else $error("block end pulse bad");
   a_reset_clean: assert property (
      $rose(resetn) |-> !wb_ack_o && !ramValid &&
      blockDone == 4'h0 && perReady)
      else $error("outputs not reset");
endmodule

bind dcs_dma_channels dcs_checker #(
   .NCH(NCH), .FIFO_DEPTH(FIFO_DEPTH)) u_chk (
   .clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .perReady(perReady),
   .ramAddr(ramAddr), .ramData(ramData), .periphAddr(periphAddr),
   .ramValid(ramValid), .ramReady(ramReady), .blockDone(blockDone));

// ---- sim/dcs_ram_model.sv ----
// RAM-side sink taking the block's writes, prompt or slow.
// Assumes the block's clock and reset.
`timescale 1ns/1ps
// ************************************************************
// RAM sink
// ************************************************************
module dcs_ram_model (
   input wire logic clk,
   input wire logic resetn,
   input wire logic slow,
   input wire logic ramValid,
   input wire logic [23:0] ramAddr,
   input wire logic [15:0] ramData,
   input wire logic [15:0] periphAddr,
   output logic ramReady,
   output logic [23:0] gotAddr,
   output logic [15:0] gotData,
   output logic [15:0] gotPad,
   output int nWrites
);
   logic [1:0] waitCnt;
   // Slow mode takes one offer in three, so offers must be held
   assign ramReady = !slow || waitCnt == 2'h2;
   // Capture each accepted write
   always_ff @(posedge clk) begin
      if (!resetn) begin
         waitCnt <= 2'h0;
         nWrites <= 0;
      end else begin
         waitCnt <= (waitCnt == 2'h2) ? 2'h0 : waitCnt + 2'h1;
         if (ramValid && ramReady) begin
            gotAddr <= ramAddr;
            gotData <= ramData;
            gotPad <= periphAddr;
            nWrites <= nWrites + 1;
         end
      end
   end
endmodule

// ---- sim/tb.sv ----
// Self-checking bench for the DMA channel register block.
// Assumes the RAM sink model and bound checker are compiled first.
`timescale 1ns/1ps
`include "dcs_regs.svh"
// ************************************************************
// Bench top
// ************************************************************
module tb;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic wbCyc = 1'b0;
   logic wbStb = 1'b0;
   logic wbWe = 1'b0;
   logic [7:0] wbAdr = 8'h00;
   logic [3:0] wbSel = 4'h3;
   logic [31:0] wbDatI = 32'h0;
   logic [31:0] wbDatO;
   logic wbAck;
   logic [3:0] perReq = 4'h0;
   logic [15:0] perData = 16'h0000;
   logic perValid = 1'b0;
   logic perReady, ramValid, ramReady;
   logic slow = 1'b0;
   logic [23:0] ramAddr, gotAddr;
   logic [15:0] ramData, periphAddr, gotData, gotPad;
   logic [3:0] blockDone;
   logic [3:0] doneLog = 4'h0;
   int nWrites;
   int cycles = 0;
   int numErrors = 0;
   int checked = 0;

   always #4 clk = ~clk;

   dcs_dma_channels #(.NCH(4), .FIFO_DEPTH(16)) u_dut (
      .clk(clk), .resetn(resetn), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
      .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI),
      .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .perReq(perReq),
      .perData(perData), .perValid(perValid), .perReady(perReady),
      .ramAddr(ramAddr), .ramData(ramData), .periphAddr(periphAddr),
      .ramValid(ramValid), .ramReady(ramReady), .blockDone(blockDone));
   dcs_ram_model u_ram (
      .clk(clk), .resetn(resetn), .slow(slow), .ramValid(ramValid),
      .ramAddr(ramAddr), .ramData(ramData), .periphAddr(periphAddr),
      .ramReady(ramReady), .gotAddr(gotAddr), .gotData(gotData),
      .gotPad(gotPad), .nWrites(nWrites));

   task automatic stopTest;
      if (numErrors == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Block end log restarts at each new request; hang guard
   always @(posedge clk) begin
      doneLog <= (perReq != 4'h0) ? blockDone : doneLog | blockDone;
      cycles++;
      if (cycles > 5000) begin
         numErrors++;
         stopTest;
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         numErrors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // One classic cycle, held until ack is sampled
   task automatic wb(input logic [7:0] a, input logic w, input logic [15:0] d,
         output logic [31:0] q);
      @(posedge clk);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= w;
      wbAdr <= a;
      wbDatI <= {16'h0000, d};
      // No local limit; only the cycle guard ends a hang
      do begin
         @(posedge clk);
      end while (wbAck !== 1'b1);
      q = wbDatO;
      chk({31'h0, wbAck}, 32'h1);
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic [31:0] q;
      wb(a, 1'b1, d, q);
   endtask

   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      logic [31:0] q;
      wb(a, 1'b0, 16'h0000, q);
      chk(q, {16'h0000, e});
   endtask

   function automatic logic [7:0] ra(input int c, input logic [2:0] o);
      return 8'(c * 32) + {3'b000, o, 2'b00};
   endfunction

   // One request pulse, then compare the write the RAM side took
   task automatic xfer(input int c, input logic [23:0] ea,
         input logic [15:0] ed, input logic [15:0] ep, input logic [3:0] dn);
      int n0;
      int n;
      n0 = nWrites;
      perReq[c] <= 1'b1;
      @(posedge clk);
      perReq[c] <= 1'b0;
      n = 0;
      while (nWrites == n0 && n < 100) begin
         @(posedge clk);
         n++;
      end
      repeat (2) @(posedge clk);
      chk({8'h00, gotAddr}, {8'h00, ea});
      chk({16'h0000, gotData}, {16'h0000, ed});
      chk({16'h0000, gotPad}, {16'h0000, ep});
      chk({28'h0, doneLog}, {28'h0, dn});
   endtask

   initial begin
      logic [15:0] ev;
      int n;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      // Reset values, then width masks with all ones written
      for (int c = 0; c < 4; c++) begin
         for (int o = 1; o < 7; o++) begin
            rd(ra(c, 3'(o)), 16'h0000);
            ev = (o == 1 || o == 3) ? 16'h00FF :
               (o == 6 ? 16'h3FFF : 16'hFFFF);
            wr(ra(c, 3'(o)), 16'hFFFF);
            rd(ra(c, 3'(o)), ev);
         end
      end
      // Status is read-only; writes there and to a hole change nothing
      for (int a = 8'h80; a < 8'h98; a += 4) begin
         wr(8'(a), 16'hFFFF);
         rd(8'(a), (a == 8'h90) ? 16'h000F : 16'h0000);
      end
      wr(8'h1C, 16'hFFFF);
      rd(8'h1C, 16'h0000);
      // Collisions on channel 0 with an empty buffer, so nothing moves
      wr(ra(0, `DCS_OFS_CTRL), 16'h0001);
      perReq[0] <= 1'b1;
      repeat (2) @(posedge clk);
      perReq[0] <= 1'b0;
      rd(8'h88, 16'h0001);
      rd(8'h8C, 16'h0000);
      wr(ra(0, `DCS_OFS_CTRL), 16'h0005);
      perReq[0] <= 1'b1;
      @(posedge clk);
      perReq[0] <= 1'b0;
      rd(8'h8C, 16'h0001);
      wr(ra(0, `DCS_OFS_CTRL), 16'h0001);
      rd(ra(0, `DCS_OFS_CTRL), 16'h0005);
      wr(ra(0, `DCS_OFS_CTRL), 16'h0000);
      rd(ra(0, `DCS_OFS_CTRL), 16'h0000);
      rd(8'h88, 16'h0000);
      rd(8'h8C, 16'h0000);
      // Fill the buffer until it refuses
      perValid <= 1'b1;
      perData <= 16'hD000;
      n = 0;
      repeat (20) begin
         @(posedge clk);
         if (perReady === 1'b1) begin
            n++;
            perData <= perData + 16'h0001;
         end
      end
      perValid <= 1'b0;
      chk(n, 32'd16);
      // Block of sixteen on channel 3, crossing a 64K line, RAM stalling
      wr(ra(3, `DCS_OFS_PRIM_HI), 16'h0012);
      wr(ra(3, `DCS_OFS_PRIM_LO), 16'hFFF8);
      wr(ra(3, `DCS_OFS_PAD), 16'h4A6C);
      wr(ra(3, `DCS_OFS_CNT), 16'h000F);
      wr(ra(3, `DCS_OFS_CTRL), 16'h0001);
      slow <= 1'b1;
      for (int i = 0; i < 16; i++) begin
         xfer(3, 24'h12FFF8 + 24'(i), 16'hD000 + 16'(i), 16'h4A6C,
            (i == 15) ? 4'h8 : 4'h0);
      end
      slow <= 1'b0;
      chk({31'h0, perReady}, 32'h1);
      rd(8'h80, 16'h0013);
      rd(8'h84, 16'h0007);
      rd(8'h90, 16'h0003);
      // Ping-pong on channel 2, one word per block
      wr(ra(2, `DCS_OFS_PRIM_HI), 16'h0000);
      wr(ra(2, `DCS_OFS_PRIM_LO), 16'h0100);
      wr(ra(2, `DCS_OFS_SEC_HI), 16'h0005);
      wr(ra(2, `DCS_OFS_SEC_LO), 16'h0200);
      wr(ra(2, `DCS_OFS_CNT), 16'h0000);
      wr(ra(2, `DCS_OFS_CTRL), 16'h0003);
      perValid <= 1'b1;
      perData <= 16'hE000;
      @(posedge clk);
      perData <= 16'hE001;
      @(posedge clk);
      perValid <= 1'b0;
      xfer(2, 24'h000100, 16'hE000, 16'hFFFF, 4'h4);
      rd(8'h94, 16'h0004);
      xfer(2, 24'h050200, 16'hE001, 16'hFFFF, 4'h4);
      rd(8'h94, 16'h0000);
      rd(8'h90, 16'h0002);
      stopTest;
   end
endmodule
